// [src/icl_map.svh]
// Register offsets, bit positions and reset values of the interrupt clear bank
`ifndef ICL_MAP_SVH
`define ICL_MAP_SVH

// ****************************************
// Clearing register offsets
// ****************************************
`define ICL_OFS_REF_AB      16'h0A07
`define ICL_OFS_REF_CD      16'h0A08
`define ICL_OFS_L0_LOCK     16'h0A09
`define ICL_OFS_L0_STATE    16'h0A0A
`define ICL_OFS_L0_MISC     16'h0A0B
`define ICL_OFS_L1_LOCK     16'h0A0C
`define ICL_OFS_L1_STATE    16'h0A0D
`define ICL_OFS_L1_MISC     16'h0A0E

// ****************************************
// Mask register offsets, same order
// ****************************************
`define ICL_MSK_REF_AB      16'h0B07
`define ICL_MSK_REF_CD      16'h0B08
`define ICL_MSK_L0_LOCK     16'h0B09
`define ICL_MSK_L0_STATE    16'h0B0A
`define ICL_MSK_L0_MISC     16'h0B0B
`define ICL_MSK_L1_LOCK     16'h0B0C
`define ICL_MSK_L1_STATE    16'h0B0D
`define ICL_MSK_L1_MISC     16'h0B0E

// ****************************************
// Bank indices, bit masks and values
// ****************************************
`define ICL_IDX_REF_AB      0
`define ICL_IDX_REF_CD      1
`define ICL_IDX_L0_LOCK     2
`define ICL_IDX_L0_STATE    3
`define ICL_IDX_L0_MISC     4
`define ICL_IDX_L1_LOCK     5
`define ICL_IDX_L1_STATE    6
`define ICL_IDX_L1_MISC     7
`define ICL_NUM_REGS        8
`define ICL_REF_VALID       8'h77
`define ICL_FULL_VALID      8'hFF
`define ICL_ZERO_BYTE       8'h00
`define ICL_RSVD_LO         3
`define ICL_RSVD_HI         7

`endif

// [src/icl_pkg.sv]
// Types shared by the interrupt clear bank
package icl_pkg;
    // Register port request, one cycle per access
    typedef struct packed {
        logic [15:0] addr;   // Byte address
        logic [7:0]  wdata;  // Write data
        logic        wr;     // Write strobe
        logic        rd;     // Read strobe
    } icl_bus_req_t;

    // Eight byte-wide registers of flags or clears
    typedef logic [7:0][7:0] icl_bank_t;
endpackage

// [src/icl_irq_clear.sv]
// Interrupt clear bank for reference inputs and loops 0 and 1
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "icl_map.svh"

module icl_irq_clear (
    // Clock and reset
    input  wire logic                REF_CLK_I,
    input  wire logic                RST_N_I,
    // Register port
    input  wire icl_pkg::icl_bus_req_t BUS_REQ_I,
    output var  logic [7:0]          RD_DATA_O,
    // Event pulses from the monitors
    input  wire icl_pkg::icl_bank_t  EVT_I,
    // Monitor flags and clear pulses
    output var  icl_pkg::icl_bank_t  FLAG_O,
    output var  icl_pkg::icl_bank_t  CLR_PULSE_O,
    // Interrupt request
    output var  logic                IRQ_O
);
    import icl_pkg::*;

    // ****************************************
    // Address tables
    // ****************************************

    // Clearing register offsets by bank index
    localparam logic [15:0] CLR_OFS [`ICL_NUM_REGS] = '{
        `ICL_OFS_REF_AB, `ICL_OFS_REF_CD,
        `ICL_OFS_L0_LOCK, `ICL_OFS_L0_STATE, `ICL_OFS_L0_MISC,
        `ICL_OFS_L1_LOCK, `ICL_OFS_L1_STATE, `ICL_OFS_L1_MISC};

    // Mask register offsets by bank index
    localparam logic [15:0] MSK_OFS [`ICL_NUM_REGS] = '{
        `ICL_MSK_REF_AB, `ICL_MSK_REF_CD,
        `ICL_MSK_L0_LOCK, `ICL_MSK_L0_STATE, `ICL_MSK_L0_MISC,
        `ICL_MSK_L1_LOCK, `ICL_MSK_L1_STATE, `ICL_MSK_L1_MISC};

    // ****************************************
    // Storage
    // ****************************************

    icl_bank_t   flag_reg;      // Latched monitor flags
    icl_bank_t   flag_next;     // Next flag values
    icl_bank_t   mask_reg;      // Interrupt enables
    icl_bank_t   mask_next;     // Next interrupt enables
    icl_bank_t   clr_reg;       // Self-clearing clear bits
    icl_bank_t   clr_now;       // Clears applied this cycle
    icl_bank_t   valid;         // Implemented bit positions
    logic [7:0]  wr_clr_hit;    // Write hits a clearing register
    logic [7:0]  wr_msk_hit;    // Write hits a mask register
    logic [7:0]  rd_clr_hit;    // Read hits a clearing register
    logic [7:0]  rd_msk_hit;    // Read hits a mask register
    logic [7:0]  rd_data_reg;   // Read data, one cycle late
    logic [7:0]  rd_data_next;  // Read data being selected
    logic        irq_reg;       // Registered interrupt level

    // ****************************************
    // Per-register decode and flag logic
    // ****************************************

    for (genvar r = 0; r < `ICL_NUM_REGS; r++) begin : g_bank
        // Reference registers hold reserved bits 3 and 7
        assign valid[r] = (r < `ICL_IDX_L0_LOCK) ? `ICL_REF_VALID : `ICL_FULL_VALID;

        // Address decode for writes and reads
        assign wr_clr_hit[r] = BUS_REQ_I.wr && (BUS_REQ_I.addr == CLR_OFS[r]);
        assign wr_msk_hit[r] = BUS_REQ_I.wr && (BUS_REQ_I.addr == MSK_OFS[r]);
        assign rd_clr_hit[r] = BUS_REQ_I.rd && (BUS_REQ_I.addr == CLR_OFS[r]);
        assign rd_msk_hit[r] = BUS_REQ_I.rd && (BUS_REQ_I.addr == MSK_OFS[r]);

        // Only ones on implemented bits clear anything
        assign clr_now[r] = wr_clr_hit[r] ? (BUS_REQ_I.wdata & valid[r])
                                          : `ICL_ZERO_BYTE;

        // New events win over a clear in the same cycle
        assign flag_next[r] = (flag_reg[r] & ~clr_now[r])
                            | (EVT_I[r] & valid[r]);

        // Mask write value; reserved positions stay zero
        assign mask_next[r] = wr_msk_hit[r] ? (BUS_REQ_I.wdata & valid[r])
                                            : mask_reg[r];

        // Monitor flag update
        always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
            if (!RST_N_I) begin
                flag_reg[r] <= `ICL_ZERO_BYTE;
            end else begin
                flag_reg[r] <= flag_next[r];
            end
        end

        // Clear bits stand for one cycle, then drop
        always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
            if (!RST_N_I) begin
                clr_reg[r] <= `ICL_ZERO_BYTE;
            end else begin
                clr_reg[r] <= clr_now[r];
            end
        end

        // Mask register write
        always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
            if (!RST_N_I) begin
                mask_reg[r] <= `ICL_ZERO_BYTE;
            end else begin
                mask_reg[r] <= mask_next[r];
            end
        end
    end

    // ****************************************
    // Read path
    // ****************************************

    // Select flags or mask; unmapped reads give zero
    always_comb begin
        rd_data_next = `ICL_ZERO_BYTE;
        for (int i = 0; i < `ICL_NUM_REGS; i++) begin
            if (rd_clr_hit[i]) begin
                rd_data_next = flag_reg[i];
            end
            if (rd_msk_hit[i]) begin
                rd_data_next = mask_reg[i];
            end
        end
    end

    // Read data valid in the cycle after the strobe only
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rd_data_reg <= `ICL_ZERO_BYTE;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    // ****************************************
    // Interrupt output
    // ****************************************

    // Level request while any unmasked flag is set; next flags and
    // next masks, so a flag or mask write moves the request at once
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(flag_next & mask_next);
        end
    end

    // Outputs from flip-flops
    assign RD_DATA_O   = rd_data_reg;
    assign FLAG_O      = flag_reg;
    assign CLR_PULSE_O = clr_reg;
    assign IRQ_O       = irq_reg;

    // ****************************************
    // Assertions
    // ****************************************

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    // Reference A fault flag clears on bit 0
    AST_REF_INPUT_A_FAULT_CLR: assert property (
        wr_clr_hit[`ICL_IDX_REF_AB] && BUS_REQ_I.wdata[0] && !EVT_I[`ICL_IDX_REF_AB][0]
        |=> !flag_reg[`ICL_IDX_REF_AB][0])
        else $error("reference A fault flag not cleared");

    // Reference D validated flag clears on bit 6
    AST_REF_INPUT_D_VALID_CLR: assert property (
        wr_clr_hit[`ICL_IDX_REF_CD] && BUS_REQ_I.wdata[6] && !EVT_I[`ICL_IDX_REF_CD][6]
        |=> !flag_reg[`ICL_IDX_REF_CD][6])
        else $error("reference D validated flag not cleared");

    // Loop 0 clamp exit flag clears on bit 7
    AST_L0_CLAMP_CLR: assert property (
        flag_reg[`ICL_IDX_L0_LOCK][7] && wr_clr_hit[`ICL_IDX_L0_LOCK]
        && BUS_REQ_I.wdata[7] && !EVT_I[`ICL_IDX_L0_LOCK][7]
        |=> $fell(flag_reg[`ICL_IDX_L0_LOCK][7]))
        else $error("loop 0 clamp exit flag not cleared");

    // Loop 0 slew entry clears on bit 4 and leaves bit 5 alone
    AST_L0_SLEW_CLR: assert property (
        wr_clr_hit[`ICL_IDX_L0_LOCK] && BUS_REQ_I.wdata[5:4] == 2'h1
        && !EVT_I[`ICL_IDX_L0_LOCK][4]
        |=> !flag_reg[`ICL_IDX_L0_LOCK][4]
        && flag_reg[`ICL_IDX_L0_LOCK][5]
           == ($past(flag_reg[`ICL_IDX_L0_LOCK][5]) | $past(EVT_I[`ICL_IDX_L0_LOCK][5])))
        else $error("loop 0 slew flags handled wrongly");

    // Loop 0 lock nibble clears together
    AST_L0_LOCK_CLR: assert property (
        wr_clr_hit[`ICL_IDX_L0_LOCK] && BUS_REQ_I.wdata[3:0] == 4'hF
        && EVT_I[`ICL_IDX_L0_LOCK][3:0] == 4'h0
        |=> flag_reg[`ICL_IDX_L0_LOCK][3:0] == 4'h0)
        else $error("loop 0 lock flags not cleared");

    // Loop 0 state register, both halves
    AST_L0_STATE_CLR: assert property (
        wr_clr_hit[`ICL_IDX_L0_STATE] && BUS_REQ_I.wdata == 8'hFF
        && EVT_I[`ICL_IDX_L0_STATE] == 8'h00
        |=> flag_reg[`ICL_IDX_L0_STATE] == 8'h00)
        else $error("loop 0 state flags not cleared");

    // Loop 0 misc register, including analog loop 0
    AST_L0_MISC_CLR: assert property (
        wr_clr_hit[`ICL_IDX_L0_MISC] && !EVT_I[`ICL_IDX_L0_MISC][7]
        && !EVT_I[`ICL_IDX_L0_MISC][0] && BUS_REQ_I.wdata[7] && BUS_REQ_I.wdata[0]
        |=> !flag_reg[`ICL_IDX_L0_MISC][7] && !flag_reg[`ICL_IDX_L0_MISC][0])
        else $error("loop 0 misc flags not cleared");

    // Loop 1 lock register, full byte
    AST_L1_LOCK_CLR: assert property (
        wr_clr_hit[`ICL_IDX_L1_LOCK] && EVT_I[`ICL_IDX_L1_LOCK] == 8'h00
        |=> flag_reg[`ICL_IDX_L1_LOCK] == ($past(flag_reg[`ICL_IDX_L1_LOCK]) & ~$past(BUS_REQ_I.wdata)))
        else $error("loop 1 lock flags wrong after clear");

    // Loop 1 state register, full byte
    AST_L1_OTHER_CLR: assert property (
        wr_clr_hit[`ICL_IDX_L1_STATE] && BUS_REQ_I.wdata == 8'hFF
        && EVT_I[`ICL_IDX_L1_STATE] == 8'h00
        |=> flag_reg[`ICL_IDX_L1_STATE] == 8'h00)
        else $error("loop 1 state flags not cleared");

    // Loop 1 misc register, including analog loop 1
    AST_L1_MISC_CLR: assert property (
        wr_clr_hit[`ICL_IDX_L1_MISC] && BUS_REQ_I.wdata == 8'hFF
        && EVT_I[`ICL_IDX_L1_MISC] == 8'h00
        |=> flag_reg[`ICL_IDX_L1_MISC] == 8'h00)
        else $error("loop 1 misc flags not cleared");

    // Event in the clear cycle survives
    AST_SET_WINS: assert property (
        EVT_I[`ICL_IDX_L1_MISC][3] |=> flag_reg[`ICL_IDX_L1_MISC][3])
        else $error("event lost against clear");

    // Clearing the only unmasked flag drops the request
    AST_IRQ_DROP: assert property (
        wr_clr_hit[`ICL_IDX_REF_AB] && BUS_REQ_I.wdata == 8'hFF
        && EVT_I == '0 && (flag_reg & mask_reg) == icl_bank_t'({56'h0, flag_reg[0] & mask_reg[0]})
        |=> !IRQ_O)
        else $error("interrupt stayed high after clear");

    // Clear bits drop one cycle after the write
    AST_CLR_SELF: assert property (
        wr_clr_hit[`ICL_IDX_L0_MISC] && BUS_REQ_I.wdata != 8'h00
        ##1 !wr_clr_hit[`ICL_IDX_L0_MISC]
        |=> $past(clr_reg[`ICL_IDX_L0_MISC]) != 8'h00 && clr_reg[`ICL_IDX_L0_MISC] == 8'h00)
        else $error("clear bits did not return to zero");

    // Zero writes leave flags untouched
    AST_ZERO_WRITE: assert property (
        wr_clr_hit[`ICL_IDX_L0_STATE] && BUS_REQ_I.wdata == 8'h00
        |=> flag_reg[`ICL_IDX_L0_STATE] == ($past(flag_reg[`ICL_IDX_L0_STATE]) | $past(EVT_I[`ICL_IDX_L0_STATE])))
        else $error("zero write changed flags");

    // Reserved bits never hold a flag
    AST_RSVD_IDLE: assert property (
        !flag_reg[`ICL_IDX_REF_AB][`ICL_RSVD_LO] && !flag_reg[`ICL_IDX_REF_CD][`ICL_RSVD_HI]
        && !clr_reg[`ICL_IDX_REF_CD][`ICL_RSVD_LO])
        else $error("reserved bit became active");

    // Read data follows a strobe by one cycle
    AST_READ_LATE: assert property (
        rd_clr_hit[`ICL_IDX_L1_MISC] |=> RD_DATA_O == $past(flag_reg[`ICL_IDX_L1_MISC]))
        else $error("read data wrong or late");

    // ****************************************
    // Further checks
    // ****************************************

    // Reference B validated flag clears on bit 6
    AST_REF_INPUT_B_VALID_CLR: assert property (
        wr_clr_hit[`ICL_IDX_REF_AB] && BUS_REQ_I.wdata[6] && !EVT_I[`ICL_IDX_REF_AB][6]
        |=> !flag_reg[`ICL_IDX_REF_AB][6])
        else $error("reference B validated flag not cleared");

    // Reference C fault flag clears on bit 0
    AST_REF_INPUT_C_FAULT_CLR: assert property (
        wr_clr_hit[`ICL_IDX_REF_CD] && BUS_REQ_I.wdata[0] && !EVT_I[`ICL_IDX_REF_CD][0]
        |=> !flag_reg[`ICL_IDX_REF_CD][0])
        else $error("reference C fault flag not cleared");

    // Loop 1 phase step flag clears on bit 7
    AST_L1_STEP_CLR: assert property (
        wr_clr_hit[`ICL_IDX_L1_MISC] && BUS_REQ_I.wdata[7] && !EVT_I[`ICL_IDX_L1_MISC][7]
        |=> !flag_reg[`ICL_IDX_L1_MISC][7])
        else $error("loop 1 phase step flag not cleared");

    // Loop 0 history flag clears on bit 4 of the state register
    AST_L0_HIST_CLR: assert property (
        wr_clr_hit[`ICL_IDX_L0_STATE] && BUS_REQ_I.wdata[4] && !EVT_I[`ICL_IDX_L0_STATE][4]
        |=> !flag_reg[`ICL_IDX_L0_STATE][4])
        else $error("loop 0 history flag not cleared");

    // A reserved-only write to the reference row changes no flag
    AST_RSVD_WRITE: assert property (
        wr_clr_hit[`ICL_IDX_REF_AB] && (BUS_REQ_I.wdata & `ICL_REF_VALID) == 8'h00
        && EVT_I[`ICL_IDX_REF_AB] == 8'h00
        |=> $stable(flag_reg[`ICL_IDX_REF_AB]))
        else $error("reserved write changed reference flags");

    // Reserved clear bits never pulse
    AST_CLR_RSVD_ZERO: assert property (
        (clr_reg[`ICL_IDX_REF_AB] & ~`ICL_REF_VALID) == 8'h00
        && (clr_reg[`ICL_IDX_REF_CD] & ~`ICL_REF_VALID) == 8'h00)
        else $error("reserved clear bit pulsed");

    // Clear pulses copy the ones written in the previous cycle
    AST_CLR_PULSE: assert property (
        wr_clr_hit[`ICL_IDX_L0_LOCK] |=> clr_reg[`ICL_IDX_L0_LOCK] == $past(BUS_REQ_I.wdata))
        else $error("clear pulse does not match the write");

    // Flags rise only on an event
    AST_FLAG_RISE_EVT: assert property (
        EVT_I == '0 |=> (flag_reg & ~$past(flag_reg)) == '0)
        else $error("flag set without an event");

    // Mask write stores only implemented bits
    AST_MASK_WRITE: assert property (
        wr_msk_hit[`ICL_IDX_REF_AB]
        |=> mask_reg[`ICL_IDX_REF_AB] == ($past(BUS_REQ_I.wdata) & `ICL_REF_VALID))
        else $error("mask write stored wrong bits");

    // Masks change only when a mask register is written
    AST_MASK_HOLD: assert property (
        wr_msk_hit == 8'h00 |=> $stable(mask_reg))
        else $error("mask changed without a write");

    // Request level always follows the unmasked flags
    AST_IRQ_LEVEL: assert property (
        IRQ_O == |(flag_reg & mask_reg))
        else $error("interrupt level does not match flags");

    // Read data is zero in a cycle after no read
    AST_RD_IDLE_ZERO: assert property (
        !BUS_REQ_I.rd |=> RD_DATA_O == 8'h00)
        else $error("read data stood too long");

    // Mask registers read back through the port
    AST_MASK_READ: assert property (
        rd_msk_hit[`ICL_IDX_L0_MISC] |=> RD_DATA_O == $past(mask_reg[`ICL_IDX_L0_MISC]))
        else $error("mask read data wrong");

    // Reads of unmapped addresses return zero
    AST_UNMAPPED_READ: assert property (
        BUS_REQ_I.rd && rd_clr_hit == 8'h00 && rd_msk_hit == 8'h00 |=> RD_DATA_O == 8'h00)
        else $error("unmapped read returned data");

    // Every row: a clear write removes exactly the written ones
    for (genvar k = 0; k < `ICL_NUM_REGS; k++) begin : g_row_chk
        AST_ROW_CLR: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
            wr_clr_hit[k] && EVT_I[k] == 8'h00
            |=> flag_reg[k] == ($past(flag_reg[k]) & ~$past(BUS_REQ_I.wdata)))
            else $error("row flags wrong after clear");
    end

endmodule
`default_nettype wire

// [sim/icl_tb.sv]
// Self-checking bench for the interrupt clear bank
`timescale 1ns/1ps
`default_nettype none
`include "icl_map.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %s exp=%h got=%h", nm, e, g); end end

module testbench;
    import icl_pkg::*;
    // ****************************************
    // Signals and bench state
    // ****************************************
    logic         clk;         // System clock
    logic         rst_n;       // Async reset, low active
    icl_bus_req_t bus_req;     // Register port request
    logic [7:0]   rd_data;     // Read data
    icl_bank_t    evt;         // Event pulses
    icl_bank_t    flag;        // Monitor flags
    icl_bank_t    clr_pulse;   // Clear pulses
    logic         irq;         // Interrupt request
    icl_bank_t    exp_flag;    // Model of the flags
    icl_bank_t    exp_mask;    // Model of the masks
    logic [7:0]   rd_q[$];     // Expected read data, oldest first
    logic [7:0]   rd_exp;      // Note taken off the queue
    logic         rd_d;        // A read was taken at the last edge
    logic [15:0]  a;           // Random address
    logic [31:0]  pick;        // Random selector
    int           fail_count;  // Mismatches
    int           n_checks;    // Comparisons
    int           seed;        // Random seed
    // Reserved bits of the reference rows never latch
    localparam icl_bank_t EVT_OK = {{6{8'hFF}}, 8'h77, 8'h77};

    // Device under test
    icl_irq_clear i_dut (
        .REF_CLK_I   (clk),
        .RST_N_I     (rst_n),
        .BUS_REQ_I   (bus_req),
        .RD_DATA_O   (rd_data),
        .EVT_I       (evt),
        .FLAG_O      (flag),
        .CLR_PULSE_O (clr_pulse),
        .IRQ_O       (irq)
    );

    // Clock, 20 ns period
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ****************************************
    // Address decode helpers
    // ****************************************
    // Writable bits of a mapped byte, zero when unmapped
    function automatic logic [7:0] valid_bits(input logic [15:0] ad);
        if (!(ad[15:8] inside {8'h0A, 8'h0B}) || ad[7:0] < 8'h07 || ad[7:0] > 8'h0E) return `ICL_ZERO_BYTE;
        return (ad[7:0] <= 8'h08) ? `ICL_REF_VALID : `ICL_FULL_VALID;
    endfunction

    // Bank row of a byte address
    function automatic int row(input logic [15:0] ad);
        return int'(3'(ad[3:0] + 4'h1));
    endfunction

    // ****************************************
    // Drivers
    // ****************************************
    // Flags and request against the model
    task automatic check_state();
        `CHK("flags", exp_flag, flag)
        `CHK("irq", |(exp_flag & exp_mask), irq)
    endtask

    // One write, optional events in the same cycle
    task automatic wr_reg(input logic [15:0] ad, input logic [7:0] d, input icl_bank_t e);
        icl_bank_t clr;
        clr = '0;
        if (ad[15:8] == 8'h0A) clr[row(ad)] = d & valid_bits(ad);
        bus_req.addr  <= ad;
        bus_req.wdata <= d;
        bus_req.wr    <= 1'b1;
        evt           <= e;
        @(posedge clk);
        bus_req.wr <= 1'b0;
        evt        <= '0;
        // Set wins over clear
        exp_flag = (exp_flag & ~clr) | e;
        if (ad[15:8] == 8'h0B && valid_bits(ad) != 8'h00) exp_mask[row(ad)] = d & valid_bits(ad);
        @(negedge clk);
        `CHK("clear pulse", clr, clr_pulse)
        check_state();
        @(posedge clk);
        @(negedge clk);
        `CHK("clear idle", icl_bank_t'('0), clr_pulse)
        @(posedge clk);
    endtask

    // One read, expected byte noted in the queue
    task automatic rd_reg(input logic [15:0] ad);
        bus_req.addr <= ad;
        bus_req.rd   <= 1'b1;
        rd_q.push_back((ad[8] ? exp_mask[row(ad)] : exp_flag[row(ad)]) & valid_bits(ad));
        @(posedge clk);
        bus_req.rd <= 1'b0;
        @(posedge clk);
    endtask

    // ****************************************
    // Read data watcher
    // ****************************************
    always @(posedge clk) rd_d <= bus_req.rd;

    // Data stand in the cycle after the read
    always @(negedge clk) begin
        if (rd_d === 1'b1) begin
            if (rd_q.size() == 0) begin
                fail_count++;
                $display("[FAIL] read data exp=none got=%h", rd_data);
            end else begin
                rd_exp = rd_q.pop_front();
                `CHK("read data", rd_exp, rd_data)
            end
        end
    end

    // Verdict and end of run
    task automatic finish_test();
        $display("checks=%0d failures=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("[FAIL] run exp=done got=timeout");
        finish_test();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        seed = 88;
        fail_count = 0;
        n_checks = 0;
        rst_n = 1'b0;
        bus_req = '0;
        evt = '0;
        exp_flag = '0;
        exp_mask = '0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check_state();
        @(posedge clk);
        // Each clear bit alone drops only its own flag
        for (int r = 0; r < 8; r++) begin
            for (int b = 0; b < 8; b++) begin
                wr_reg(16'h0A07 + 16'(r), 8'h00, EVT_OK);
                wr_reg(16'h0A07 + 16'(r), 8'h01 << b, '0);
                rd_reg(16'h0A07 + 16'(r));
            end
        end
        // Unmask everything so the request follows the flags
        for (int r = 0; r < 8; r++) begin
            wr_reg(16'h0B07 + 16'(r), 8'hFF, EVT_OK);
            rd_reg(16'h0B07 + 16'(r));
        end
        // Random traffic, unmapped bytes and zero bits included
        repeat (60) begin
            pick = $random(seed);
            a = {(pick[8] ? 8'h0B : 8'h0A), 8'h05 + 8'(pick[3:0])};
            wr_reg(a, 8'($random(seed)), {$random(seed), $random(seed)} & EVT_OK);
            rd_reg(a);
        end
        // Clear everything, reference row last, request must drop
        for (int r = 7; r >= 0; r--) wr_reg(16'h0A07 + 16'(r), 8'hFF, '0);
        @(negedge clk);
        `CHK("irq low", 1'b0, irq)
        // Reserved-only write to a full reference row changes nothing
        @(posedge clk);
        wr_reg(16'h0A07, 8'h00, EVT_OK);
        wr_reg(16'h0A07, 8'h88, '0);
        // Reset in mid-run drops flags, masks and request
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        exp_flag = '0;
        exp_mask = '0;
        @(negedge clk);
        check_state();
        `CHK("clear idle after reset", icl_bank_t'('0), clr_pulse)
        @(posedge clk);
        rd_reg(16'h0B0E);
        rd_reg(16'h0A07);
        finish_test();
    end
endmodule

`default_nettype wire
